// ---- pkg/psc_pkg.sv ----
// shared constants, types and helpers of the serial control and fault port
// assumes a 40 MHz system clock and a host-driven serial clock of its own
package psc_pkg;

	// -----------------------------------------------------------------
	// geometry and clock
	// -----------------------------------------------------------------
	localparam int PSC_CH = 4;
	localparam int PSC_FAULT_MSB = 3;
	localparam int PSC_CLK_PERIOD_NS = 25;

	// -----------------------------------------------------------------
	// times as printed, and their cycle counts (rounded up)
	// -----------------------------------------------------------------
	localparam int PSC_FAULT_MASK_TIME_US = 60;
	localparam int PSC_SHORT_DEGLITCH_TIME_US = 8;
	localparam int PSC_RETRY_PULSE_WIDTH_US = 68;
	localparam int PSC_RETRY_REFRESH_PERIOD_MS = 10;
	localparam int PSC_MASK_CYC =
		(PSC_FAULT_MASK_TIME_US * 1000 + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;
	localparam int PSC_DG_CYC =
		(PSC_SHORT_DEGLITCH_TIME_US * 1000 + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;
	localparam int PSC_PULSE_CYC =
		(PSC_RETRY_PULSE_WIDTH_US * 1000 + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;
	localparam int PSC_REFRESH_CYC =
		(PSC_RETRY_REFRESH_PERIOD_MS * 1000000 + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;

	// -----------------------------------------------------------------
	// counter widths and load values
	// -----------------------------------------------------------------
	localparam int PSC_MASK_W = 12;
	localparam int PSC_DG_W = 9;
	localparam int PSC_PULSE_W = 12;
	localparam int PSC_REF_W = 19;
	localparam logic [PSC_MASK_W-1:0] PSC_MASK_LOAD = PSC_MASK_W'(PSC_MASK_CYC);
	localparam logic [PSC_DG_W-1:0] PSC_DG_DONE = PSC_DG_W'(PSC_DG_CYC);
	localparam logic [PSC_PULSE_W-1:0] PSC_PULSE_LOAD = PSC_PULSE_W'(PSC_PULSE_CYC);

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [PSC_CH-1:0] PSC_CTRL_RST = 4'h0;
	localparam logic [PSC_CH-1:0] PSC_FAULT_RST = 4'h0;

	// -----------------------------------------------------------------
	// channel states and pin carriers
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		PSC_CH_NORMAL = 2'h0,
		PSC_CH_LATCH = 2'h1,
		PSC_CH_RETRY = 2'h2
	} psc_ch_state_t;

	typedef struct packed {
		logic data;
		logic oe;
	} psc_serial_out_t;

	typedef struct packed {
		logic level;
		logic oe;
	} psc_flag_pin_t;

	// a channel reports a fault in any state but normal
	function automatic logic psc_ch_faulted(input psc_ch_state_t st);
		psc_ch_faulted = (st != PSC_CH_NORMAL);
	endfunction : psc_ch_faulted

endpackage : psc_pkg

// ---- hw/psc_sync.sv ----
// two-flop level synchroniser for pins entering the system clock domain
// assumes inputs are quasi-static levels relative to the system clock
module psc_sync
	import psc_pkg::*;
#(
	parameter int W = 1
)
(
	// clock and control
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else if (clk_en)
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : psc_sync

// ---- hw/psc_port.sv ----
// serial control and fault readback port of a four channel low-side predriver
// assumes sclk stands still outside frames and the host keeps sclk low at select edges
module psc_port
	import psc_pkg::*;
#(
	parameter int unsigned REFRESH_CYC = PSC_REFRESH_CYC
)
(
	// system clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// configuration
	input wire logic retry_mode,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output psc_serial_out_t serial_out,
	// channel pins
	input wire logic [PSC_CH-1:0] parallel_channel_inputs,
	input wire logic [PSC_CH-1:0] drain_sense_inputs,
	output logic [PSC_CH-1:0] gate_drive_outputs,
	// fault reporting
	output psc_flag_pin_t fault_flag_n,
	output logic [PSC_CH-1:0] fault_status
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	localparam logic [PSC_REF_W-1:0] REF_LOAD = PSC_REF_W'(REFRESH_CYC - 1);

	logic [PSC_CH-1:0] shift_r;
	logic first_r;
	logic tog_r;
	logic started_r;
	logic sdo_r;

	logic cs_s;
	logic sel_s;
	logic tog_s;
	logic [PSC_CH-1:0] par_s;
	logic [PSC_CH-1:0] drain_s;
	logic cs_d_r;
	logic cs_fall;
	logic cs_rise;
	logic tog_base_r;

	logic [PSC_CH-1:0] snap_r;
	logic [PSC_CH-1:0] ctrl_r;
	logic [PSC_CH-1:0] live;
	logic flag_r;

	logic [PSC_CH-1:0] cmd_on;
	logic [PSC_CH-1:0] gate_nxt;
	logic [PSC_CH-1:0] short_hit;
	logic [PSC_CH-1:0] pulse_end;
	psc_ch_state_t state_r [PSC_CH];
	logic [PSC_MASK_W-1:0] mask_r [PSC_CH];
	logic [PSC_DG_W-1:0] dg_r [PSC_CH];
	logic [PSC_PULSE_W-1:0] pulse_r [PSC_CH];
	logic [PSC_REF_W-1:0] ref_r [PSC_CH];
	logic [PSC_CH-1:0] hit_r;

	// ---------------------------------------------------------------
	// link side, clocked by sclk and framed by chip select
	// ---------------------------------------------------------------

	// marks the first rising edge of a frame; select high rearms it
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			first_r <= 1'b1;
		else
			first_r <= 1'b0;
	end

	// shift in at lsb; first edge preloads the frozen fault word
	always_ff @(posedge sclk)
	begin
		if (!cs_n)
		begin
			if (first_r)
				shift_r <= {snap_r[PSC_FAULT_MSB-1:0], sdi};
			else
				shift_r <= {shift_r[PSC_CH-2:0], sdi};
		end
	end

	// frame-clocked toggle, tells the system side a frame saw a clock
	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
			tog_r <= 1'b0;
		else if (!cs_n)
			tog_r <= tog_r ^ first_r;
	end

	// sdo register moves on falling sclk; select high clears it
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
		begin
			started_r <= 1'b0;
			sdo_r <= 1'b0;
		end
		else
		begin
			started_r <= 1'b1;
			sdo_r <= shift_r[PSC_FAULT_MSB];
		end
	end

	// fault msb shows before the first falling edge; float while idle
	assign serial_out.data = started_r ? sdo_r : snap_r[PSC_FAULT_MSB];
	assign serial_out.oe = ~cs_n;

	// ---------------------------------------------------------------
	// crossings into the system domain
	// ---------------------------------------------------------------
	psc_sync #(
		.W(2 + 2 * PSC_CH)
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.async_in({~cs_n, tog_r, parallel_channel_inputs, drain_sense_inputs}),
		.sync_out({sel_s, tog_s, par_s, drain_s})
	);

	// select crosses active high so the stages reset to the idle level
	assign cs_s = ~sel_s;

	// select edge detection on the synchronised level
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			cs_d_r <= 1'b1;
		else if (clk_en)
			cs_d_r <= cs_s;
	end

	assign cs_fall = cs_d_r & ~cs_s;
	assign cs_rise = ~cs_d_r & cs_s;

	// toggle value seen at frame start, to detect a clockless frame
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tog_base_r <= 1'b0;
		else if (clk_en && cs_fall)
			tog_base_r <= tog_s;
	end

	// ---------------------------------------------------------------
	// fault word and control register
	// ---------------------------------------------------------------

	// fault word clears at select rise, then tracks live faults while idle; frozen during a frame
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			snap_r <= PSC_FAULT_RST;
		else if (clk_en)
		begin
			if (cs_rise)
				snap_r <= PSC_FAULT_RST;
			else if (cs_s)
				snap_r <= live;
		end
	end

	// select rise loads control; clockless frame takes fault bits
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			ctrl_r <= PSC_CTRL_RST;
		else if (clk_en && cs_rise)
		begin
			if (tog_s != tog_base_r)
				ctrl_r <= shift_r;
			else
				ctrl_r <= snap_r;
		end
	end

	// open-drain flag: faults assert it, clean select fall releases it
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			flag_r <= 1'b0;
		else if (clk_en)
		begin
			if (|live)
				flag_r <= 1'b1;
			else if (cs_fall)
				flag_r <= 1'b0;
		end
	end

	assign fault_flag_n.level = 1'b0;
	assign fault_flag_n.oe = flag_r;
	assign fault_status = live;

	// ---------------------------------------------------------------
	// per-channel gate control and shorted-load supervision
	// ---------------------------------------------------------------
	for (genvar i = 0; i < PSC_CH; i++)
	begin : g_ch

		// command sources, fault status and detector taps
		assign cmd_on[i] = ctrl_r[i] | par_s[i];
		assign live[i] = psc_ch_faulted(state_r[i]);
		assign short_hit[i] = (dg_r[i] == PSC_DG_DONE);
		assign pulse_end[i] = (pulse_r[i] == PSC_PULSE_W'(1));

		// gate request per channel state
		always_comb
		begin
			unique case (state_r[i])
				PSC_CH_NORMAL: gate_nxt[i] = cmd_on[i];
				PSC_CH_LATCH: gate_nxt[i] = 1'b0;
				PSC_CH_RETRY: gate_nxt[i] = (pulse_r[i] != '0);
				default: gate_nxt[i] = 1'b0;
			endcase
		end

		// gate output register
		always_ff @(posedge clock)
		begin
			if (!rst_n)
				gate_drive_outputs[i] <= 1'b0;
			else if (clk_en)
				gate_drive_outputs[i] <= gate_nxt[i];
		end

		// fault mask restarts at every gate transition
		always_ff @(posedge clock)
		begin
			if (!rst_n)
				mask_r[i] <= '0;
			else if (clk_en)
			begin
				if (gate_nxt[i] != gate_drive_outputs[i])
					mask_r[i] <= PSC_MASK_LOAD;
				else if (mask_r[i] != '0)
					mask_r[i] <= mask_r[i] - PSC_MASK_W'(1);
			end
		end

		// deglitch counts high drain while on and unmasked
		always_ff @(posedge clock)
		begin
			if (!rst_n)
				dg_r[i] <= '0;
			else if (clk_en)
			begin
				if (!gate_drive_outputs[i] || mask_r[i] != '0 || !drain_s[i])
					dg_r[i] <= '0;
				else if (!short_hit[i])
					dg_r[i] <= dg_r[i] + PSC_DG_W'(1);
			end
		end

		// retry refresh period and pulse timers
		always_ff @(posedge clock)
		begin
			if (!rst_n)
			begin
				ref_r[i] <= '0;
				pulse_r[i] <= '0;
			end
			else if (clk_en)
			begin
				if (state_r[i] != PSC_CH_RETRY)
				begin
					ref_r[i] <= REF_LOAD;
					pulse_r[i] <= '0;
				end
				else if (ref_r[i] == '0)
				begin
					ref_r[i] <= REF_LOAD;
					pulse_r[i] <= PSC_PULSE_LOAD;
				end
				else
				begin
					ref_r[i] <= ref_r[i] - PSC_REF_W'(1);
					if (pulse_r[i] != '0)
						pulse_r[i] <= pulse_r[i] - PSC_PULSE_W'(1);
				end
			end
		end

		// short seen during the current retry pulse
		always_ff @(posedge clock)
		begin
			if (!rst_n)
				hit_r[i] <= 1'b0;
			else if (clk_en)
			begin
				if (state_r[i] != PSC_CH_RETRY || pulse_end[i])
					hit_r[i] <= 1'b0;
				else if (short_hit[i] && gate_drive_outputs[i])
					hit_r[i] <= 1'b1; // late hit must not hold the next pulse
			end
		end

		// channel state: normal, latched off, or retrying
		always_ff @(posedge clock)
		begin
			if (!rst_n)
				state_r[i] <= PSC_CH_NORMAL;
			else if (clk_en)
			begin
				unique case (state_r[i])
					PSC_CH_NORMAL:
					begin
						if (short_hit[i] && retry_mode)
							state_r[i] <= PSC_CH_RETRY;
						else if (short_hit[i])
							state_r[i] <= PSC_CH_LATCH;
					end
					PSC_CH_LATCH:
					begin
						if (!cmd_on[i])
							state_r[i] <= PSC_CH_NORMAL;
					end
					PSC_CH_RETRY:
					begin
						if (!cmd_on[i])
							state_r[i] <= PSC_CH_NORMAL;
						else if (pulse_end[i] && !hit_r[i] && !drain_s[i])
							state_r[i] <= PSC_CH_NORMAL;
					end
					default: state_r[i] <= PSC_CH_NORMAL;
				endcase
			end
		end
	end

endmodule : psc_port

// ---- tb/psc_port_properties.sv ----
// pin-level assertions of the serial control and fault port
// assumes clk_en held high and legal host framing on the link
module psc_port_properties
	import psc_pkg::*;
#(
	parameter int unsigned REFRESH_CYC = PSC_REFRESH_CYC
)
(
	// clock, reset, config
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic retry_mode,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire psc_serial_out_t serial_out,
	// channels and faults
	input wire logic [PSC_CH-1:0] parallel_channel_inputs,
	input wire logic [PSC_CH-1:0] drain_sense_inputs,
	input wire logic [PSC_CH-1:0] gate_drive_outputs,
	input wire psc_flag_pin_t fault_flag_n,
	input wire logic [PSC_CH-1:0] fault_status
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------
	// port-wide checks
	// ------------------------------------------------
	a_sdo_follows_select: assert property (serial_out.oe == !cs_n)
		else $error("sdo enable not following select");
	a_flag_on_fault: assert property (|fault_status |=> fault_flag_n.oe)
		else $error("fault flag not raised");
	a_flag_has_cause: assert property ($rose(fault_flag_n.oe) |-> $past(|fault_status))
		else $error("fault flag raised without fault");
	a_flag_held_idle:
		assert property (cs_n && $past(cs_n, 4) && fault_flag_n.oe |=> fault_flag_n.oe)
		else $error("fault flag released outside select fall");
	a_reset_clears: assert property (@(posedge clock) disable iff (1'b0)
		!rst_n |=> gate_drive_outputs == 4'h0 && fault_status == 4'h0 && !fault_flag_n.oe)
		else $error("outputs not cleared by reset");

	// ------------------------------------------------
	// per-channel checks
	// ------------------------------------------------
	for (genvar i = 0; i < PSC_CH; i++)
	begin : g_ch
		a_mask_quiet:
			assert property ($rose(gate_drive_outputs[i]) && !fault_status[i]
				|=> !fault_status[i] [*8])
			else $error("fault reported inside mask time");
		a_latch_gate_off:
			assert property (!retry_mode && fault_status[i] && $past(fault_status[i], 2)
				|-> !gate_drive_outputs[i])
			else $error("gate on while latched off");
		a_gate_or_par:
			assert property ((parallel_channel_inputs[i] && !fault_status[i]) [*6]
				|-> gate_drive_outputs[i])
			else $error("gate off while parallel input on");
		a_fault_needs_drain:
			assert property ($rose(fault_status[i]) |-> $past(drain_sense_inputs[i], 5))
			else $error("fault without drain high");
	end

	// main scenarios reached
	c_frame: cover property ($fell(cs_n));
	c_latch: cover property (!retry_mode && $rose(|fault_status));
	c_retry_pulse: cover property (retry_mode && |(fault_status & gate_drive_outputs));
endmodule : psc_port_properties

bind psc_port psc_port_properties #(.REFRESH_CYC(REFRESH_CYC)) u_props (
	.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .retry_mode(retry_mode),
	.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .serial_out(serial_out),
	.parallel_channel_inputs(parallel_channel_inputs),
	.drain_sense_inputs(drain_sense_inputs), .gate_drive_outputs(gate_drive_outputs),
	.fault_flag_n(fault_flag_n), .fault_status(fault_status)
);

// ---- tb/psc_host.sv ----
// host model: serial bus master of the control and fault port
// assumes a system clock for framing; sclk runs at 6 ns only within frames
module psc_host
	import psc_pkg::*;
(
	// system clock
	input wire logic clock,
	// serial link
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire psc_serial_out_t serial_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle link
	initial
	begin
		cs_n = 1'b0;
		sclk = 1'b0;
		sdi = 1'b0;
		#1 cs_n = 1'b1; // clean select rise presets the link flops
	end

	// one frame of n clocks, msb first; q gathers sdo at each rise
	task automatic frame(input int n, input logic [7:0] d, output logic [7:0] q);
		q = 8'h00;
		@(posedge clock);
		cs_n <= 1'b0;
		repeat (5) @(posedge clock);
		for (int i = n - 1; i >= 0; i--) // n below four only when asked
		begin
			sdi = d[i];
			#3 sclk = 1'b1;
			q = {q[6:0], serial_out.data};
			#3 sclk = 1'b0;
		end
		#3 sdi = ~sdi;
		@(posedge clock);
		cs_n <= 1'b1;
		repeat (5) @(posedge clock);
	endtask : frame
endmodule : psc_host

// ---- tb/tb_psc_port.sv ----
// self-checking bench of the serial control and fault port
// assumes psc_host as link master and a 6000 cycle retry period
module tb_psc_port
	import psc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------
	// signals and instances
	// ------------------------------------------------
	logic clock;
	logic rst_n;
	logic retry_mode;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic [PSC_CH-1:0] par;
	logic [PSC_CH-1:0] drain;
	logic [PSC_CH-1:0] gate;
	logic [PSC_CH-1:0] fault_status;
	psc_serial_out_t serial_out;
	psc_flag_pin_t fault_flag_n;
	logic [7:0] q;
	int mismatches;
	int checks;

	psc_port #(.REFRESH_CYC(6000)) uut (
		.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .retry_mode(retry_mode),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .serial_out(serial_out),
		.parallel_channel_inputs(par), .drain_sense_inputs(drain),
		.gate_drive_outputs(gate), .fault_flag_n(fault_flag_n), .fault_status(fault_status)
	);
	psc_host u_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.serial_out(serial_out));

	// system clock
	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// bounded wait for a gate or status bit to go high
	task automatic wait_on(input bit st, input int ch, input int lim);
		repeat (lim)
			if ((st ? fault_status[ch] : gate[ch]) !== 1'b1)
				@(posedge clock);
	endtask : wait_on

	task automatic summarize();
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial
	begin
		rst_n = 1'b1;
		retry_mode = 1'b0;
		par = 4'h0;
		drain = 4'h0;
		#1 rst_n = 1'b0; // clean falling edge clears the link toggle
		tick(10);
		rst_n <= 1'b1;
		tick(4);
		chk("gate", 8'h00, {4'h0, gate});
		chk("sdo_oe", 8'h00, {7'h00, serial_out.oe});
		u_host.frame(4, 8'h0a, q);
		tick(6);
		chk("gate", 8'h0a, {4'h0, gate});
		chk("fault_word", 8'h00, q);
		u_host.frame(8, 8'h5c, q);
		tick(6);
		chk("gate", 8'h0c, {4'h0, gate});
		chk("sdo_stream", 8'h05, q);
		u_host.frame(2, 8'h02, q);
		tick(6);
		chk("gate", 8'h02, {4'h0, gate});
		par <= 4'h8;
		tick(6);
		chk("gate", 8'h0a, {4'h0, gate});
		par <= 4'h0;
		u_host.frame(4, 8'h00, q);
		tick(6);
		chk("gate", 8'h00, {4'h0, gate});
		// short on channel 0, latch-off
		par <= 4'h1;
		drain <= 4'h1;
		wait_on(0, 0, 10);
		tick(2690);
		chk("status", 8'h00, {4'h0, fault_status});
		wait_on(1, 0, 60);
		chk("status", 8'h01, {4'h0, fault_status});
		tick(3);
		chk("gate", 8'h00, {4'h0, gate});
		chk("flag_oe", 8'h01, {7'h00, fault_flag_n.oe});
		u_host.frame(4, 8'h00, q);
		chk("fault_word", 8'h01, q);
		drain <= 4'h0;
		tick(6);
		chk("status", 8'h01, {4'h0, fault_status});
		par <= 4'h0;
		tick(6);
		chk("status", 8'h00, {4'h0, fault_status});
		chk("flag_oe", 8'h01, {7'h00, fault_flag_n.oe});
		u_host.frame(4, 8'h00, q);
		chk("fault_word", 8'h00, q);
		chk("flag_oe", 8'h00, {7'h00, fault_flag_n.oe});
		par <= 4'h1;
		tick(6);
		chk("gate", 8'h01, {4'h0, gate});
		// short on channel 1, auto-retry
		retry_mode <= 1'b1;
		par <= 4'h2;
		drain <= 4'h2;
		wait_on(1, 1, 2800);
		tick(4);
		chk("gate", 8'h00, {4'h0, gate});
		wait_on(0, 1, 6100);
		tick(2700);
		chk("gate", 8'h02, {4'h0, gate});
		tick(60);
		chk("gate", 8'h00, {4'h0, gate});
		chk("status", 8'h02, {4'h0, fault_status});
		wait_on(0, 1, 6100);
		drain <= 4'h0;
		tick(2800);
		chk("status", 8'h00, {4'h0, fault_status});
		chk("gate", 8'h02, {4'h0, gate});
		summarize();
	end

	// watchdog against a hung run
	initial
	begin
		tick(40000);
		mismatches++;
		summarize();
	end
endmodule : tb_psc_port
